/* File: bench/rpc_power_ctrl_bench.sv */
// Self-checking bench for the RS-232 power-mode controller
`timescale 1ns/100ps
`default_nettype none
module rpc_power_ctrl_bench;
  import rpc_pkg::*;
  logic clk_in = 0, resetn_in = 0, sleep_req_in = 1, auto_mode_in = 0;
  logic rx_off_in = 0, line_active_in, valid = 1, pump_on;
  logic [1:0] tx_data_in = 2'h1, rx_pin_in, rx_data_out, tx_pin_out;
  logic [1:0] tx_line, line = 2'h2;
  logic [0:0] monitor_receiver_in, monitor_data_out;
  logic line_active_out, ready_out, manual_sleep_force_n_out;
  logic keep_awake_force_out, sleep_request_n_out, rx_disable_out;
  int n_mismatch = 0, total_checks = 0, n;
  rpc_power_ctrl #(.HOLD_CNT(22'h14), .TX_USED(2'h1)) dut (.clk_in,
    .resetn_in,
    .sleep_req_in, .auto_mode_in, .rx_off_in, .tx_data_in, .rx_data_out,
    .monitor_data_out, .line_active_out, .ready_out, .tx_pin_out,
    .manual_sleep_force_n_out, .keep_awake_force_out, .sleep_request_n_out,
    .rx_disable_out, .rx_pin_in, .monitor_receiver_in, .line_active_in);
  rpc_xcvr_model dev (.clk_in(clk_in), .force_n_in(manual_sleep_force_n_out),
    .awake_in(keep_awake_force_out), .sleep_request_n_n_in(sleep_request_n_out),
    .rx_dis_in(rx_disable_out), .tx_in(tx_pin_out), .valid_in(valid),
    .line_in(line), .tx_line_out(tx_line), .rx_out(rx_pin_in),
    .mon_out(monitor_receiver_in), .active_out(line_active_in),
    .pump_on_out(pump_on));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic run_all();
    tick(2);
    resetn_in <= 1'b1;
    tick(3);
    @(negedge clk_in);
    chk(manual_sleep_force_n_out, 0);
    chk(sleep_request_n_out, 0);
    chk(ready_out, 0);
    chk(tx_line, 2'hz);
    tick(1);
    sleep_req_in <= 1'b0;
    n = 0;
    while (ready_out !== 1'b1 && n < 4000) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 4000) begin
      n_mismatch++;
      return;
    end
    chk((n > WAKE_CYC) && (n < WAKE_CYC + 6), 1);
    chk({manual_sleep_force_n_out, sleep_request_n_out}, 2'h3);
    chk(keep_awake_force_out, 1);
    chk(pump_on, 1);
    chk(tx_line, 2'h2);
    chk(rx_data_out, 2'h1);
    chk(monitor_data_out, 0);
    tick(1);
    tx_data_in <= 2'h2;
    tick(1);
    @(negedge clk_in);
    chk(tx_line, 2'h3);
    tick(1);
    tx_data_in <= 2'h1;
    tick(1);
    rx_off_in <= 1'b1;
    line <= 2'h1;
    tick(4);
    @(negedge clk_in);
    chk(rx_disable_out, 1);
    chk(monitor_data_out, 1);
    chk(tx_line, 2'h2);
    tick(1);
    rx_off_in <= 1'b0;
    auto_mode_in <= 1'b1;
    tick(40);
    valid <= 1'b0;
    tick(760);
    @(negedge clk_in);
    chk(keep_awake_force_out, 0);
    chk(line_active_out, 0);
    chk(ready_out, 0);
    chk(tx_line, 2'hz);
    tick(1);
    valid <= 1'b1;
    tick(30);
    @(negedge clk_in);
    chk(line_active_out, 1);
    chk(ready_out, 1);
    chk(tx_line, 2'h2);
    tick(1);
    auto_mode_in <= 1'b0;
    rx_off_in <= 1'b1;
    tick(3);
    sleep_req_in <= 1'b1;
    line <= 2'h0;
    tick(3);
    @(negedge clk_in);
    chk(manual_sleep_force_n_out, 0);
    chk(keep_awake_force_out, 1);
    chk(ready_out, 0);
    chk(pump_on, 0);
    chk(tx_line, 2'hz);
    chk(monitor_data_out, 0);
  endtask : run_all
  initial begin
    run_all();
    wrap_up();
  end
endmodule : rpc_power_ctrl_bench
`default_nettype wire

/* File: bench/rpc_xcvr_model.sv */
// Behavioural model of the RS-232 transceiver driven by the controller
`timescale 1ns/100ps
`default_nettype none
module rpc_xcvr_model #(
  parameter int unsigned DROP_CYC = 750,
  parameter int unsigned RISE_CYC = 25,
  parameter bit          HAS_DIS  = 1'b1
) (
  input  wire logic       clk_in,
  input  wire logic       force_n_in,
  input  wire logic       awake_in,
  input  wire logic       sleep_request_n_n_in,
  input  wire logic       rx_dis_in,
  input  wire logic [1:0] tx_in,
  input  wire logic       valid_in,
  input  wire logic [1:0] line_in,
  output logic      [1:0] tx_line_out,
  output logic      [1:0] rx_out,
  output logic      [0:0] mon_out,
  output logic            active_out,
  output logic            pump_on_out
);
  int unsigned idle_cnt = 0;
  int unsigned seen_cnt = 0;
  logic [1:0]  rx_last  = 2'h0;
  logic        active   = 1'b0;
  logic        rx_hiz;
  logic        pd;
  assign active_out = active;
  always @(posedge clk_in) begin
    if (valid_in) begin
      idle_cnt <= 0;
      seen_cnt <= seen_cnt + 1;
      if (seen_cnt + 1 >= RISE_CYC) active <= 1'b1;
    end else begin
      seen_cnt <= 0;
      idle_cnt <= idle_cnt + 1;
      if (idle_cnt + 1 > DROP_CYC) active <= 1'b0;
    end
    if (!rx_hiz) rx_last <= rx_out;
  end
  // Manual pins override force-on; auto sleep needs force-on low
  assign pd = !sleep_request_n_n_in || !force_n_in ||
              (!awake_in && !active);
  // Without a disable pin, receivers float in manual sleep only
  assign rx_hiz = HAS_DIS ? rx_dis_in : (!sleep_request_n_n_in || !force_n_in);
  assign pump_on_out = !pd;
  assign tx_line_out = pd ? 2'hz : ~tx_in;
  // Released receivers show a changed level, not the last one
  assign rx_out = rx_hiz ? ~rx_last : ~line_in;
  assign mon_out = line_in[0:0];
endmodule : rpc_xcvr_model
`default_nettype wire

/* File: common/rpc_pkg.sv */
// Constants shared by the RS-232 power-mode controller
package rpc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned US_PER_S    = 1_000_000;
  localparam int unsigned WAKE_US     = 100;
  localparam int unsigned WAKE_CYC    =
    (WAKE_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
  localparam int unsigned HOLD_MS     = 100;
  localparam int unsigned HOLD_CYC    = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_W      = 12;
  localparam int unsigned HOLD_W      = 22;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    RPC_SLEEP = 2'b00,
    RPC_WAKE  = 2'b01,
    RPC_RUN   = 2'b10
  } rpc_state_e;

endpackage : rpc_pkg

/* File: core/rpc_power_ctrl.sv */
// Host-side power-mode controller for an RS-232 line transceiver
`timescale 1ns/100ps
`default_nettype none

module rpc_power_ctrl
  import rpc_pkg::*;
#(
  parameter int unsigned          TX_N      = 2,
  parameter int unsigned          RX_N      = 2,
  parameter int unsigned          MON_N     = 1,
  parameter logic [TX_N-1:0]      TX_USED   = '1,
  parameter bit                   SLEEP_REQUEST_N_USED = 1'b1,
  parameter logic [HOLD_W-1:0]    HOLD_CNT  = HOLD_W'(HOLD_CYC)
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  // User side
  input  wire logic              sleep_req_in,
  input  wire logic              auto_mode_in,
  input  wire logic              rx_off_in,
  input  wire logic [TX_N-1:0]   tx_data_in,
  output logic [RX_N-1:0]        rx_data_out,
  output logic [MON_N-1:0]       monitor_data_out,
  output logic                   line_active_out,
  output logic                   ready_out,
  // Transceiver pins
  output logic                   manual_sleep_force_n_out,
  output logic                   keep_awake_force_out,
  output logic                   sleep_request_n_out,
  output logic                   rx_disable_out,
  output logic [TX_N-1:0]        tx_pin_out,
  input  wire logic [RX_N-1:0]   rx_pin_in,
  input  wire logic [MON_N-1:0]  monitor_receiver_in,
  input  wire logic              line_active_in
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************************
  // Wake sequencer and force pins
  // ****************************************************************
  rpc_state_e         state;
  rpc_state_e         next_state;
  logic [WAKE_W-1:0]  wake_cnt;
  logic [WAKE_W-1:0]  next_wake_cnt;
  logic [HOLD_W-1:0]  hold_cnt;
  logic [HOLD_W-1:0]  next_hold_cnt;
  logic               next_force_n;
  logic               next_keep;
  logic               next_sleep_request_n_n;

  always_comb begin
    next_state    = state;
    next_wake_cnt = wake_cnt;
    next_hold_cnt = hold_cnt;
    case (state)
      RPC_SLEEP: begin
        if (!sleep_req_in) begin
          next_state    = RPC_WAKE;
          next_wake_cnt = '0;
          next_hold_cnt = HOLD_CNT;
        end
      end
      RPC_WAKE: begin
        if (sleep_req_in) begin
          next_state = RPC_SLEEP;
        end else if (wake_cnt == WAKE_W'(WAKE_CYC - 1)) begin
          next_state = RPC_RUN;
        end else begin
          next_wake_cnt = wake_cnt + WAKE_W'(1);
        end
      end
      RPC_RUN: begin
        if (sleep_req_in) begin
          next_state = RPC_SLEEP;
        end
      end
      default: begin
        next_state = RPC_SLEEP;
      end
    endcase
    if (state != RPC_SLEEP && hold_cnt != '0) begin
      next_hold_cnt = hold_cnt - HOLD_W'(1);
    end
    // Power is switched by force-off, with shutdown following it when used
    next_force_n = (next_state != RPC_SLEEP);
    // Manual-only control pins force-on high; auto mode keeps it high
    // for a hold-off after power-up so a slow peer can recover
    next_keep = !auto_mode_in || (next_hold_cnt != '0);
    // Force-on never moves in the cycle that force-off moves
    if (next_force_n != manual_sleep_force_n_out) begin
      next_keep = keep_awake_force_out;
    end
    next_sleep_request_n_n = SLEEP_REQUEST_N_USED ? next_force_n : 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state                    <= RPC_SLEEP;
      wake_cnt                 <= '0;
      hold_cnt                 <= '0;
      manual_sleep_force_n_out <= 1'b0;
      keep_awake_force_out     <= 1'b1;
      sleep_request_n_out      <= 1'b0;
    end else begin
      state                    <= next_state;
      wake_cnt                 <= next_wake_cnt;
      hold_cnt                 <= next_hold_cnt;
      manual_sleep_force_n_out <= next_force_n;
      keep_awake_force_out     <= next_keep;
      sleep_request_n_out      <= next_sleep_request_n_n;
    end
  end

  // ****************************************************************
  // Data paths
  // ****************************************************************
  logic [TX_N-1:0]  next_tx;
  logic             next_rx_dis;

  always_comb begin
    next_tx     = tx_data_in & TX_USED;
    next_rx_dis = rx_off_in;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin_out       <= '0;
      rx_disable_out   <= 1'b0;
      rx_data_out      <= '0;
      monitor_data_out <= '0;
      line_active_out  <= 1'b0;
    end else begin
      tx_pin_out       <= next_tx;
      rx_disable_out   <= next_rx_dis;
      rx_data_out      <= rx_pin_in;
      monitor_data_out <= monitor_receiver_in;
      line_active_out  <= line_active_in;
    end
  end

  // Device sits in automatic power-down when force-on is low and the
  // line-activity indicator is low
  always_comb begin
    ready_out = (state == RPC_RUN) &&
                (keep_awake_force_out || line_active_in);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_power_up;
    $rose(manual_sleep_force_n_out);
  endsequence

  sequence s_wake_quiet;
    !ready_out [*8];
  endsequence

  property p_unused_tx_low;
    @(posedge clk_in) disable iff (!rst_n)
    (tx_pin_out & ~TX_USED) == '0;
  endproperty
  a_unused_tx_low: assert property (p_unused_tx_low)
    else $error("unused transmitter input not low");

  property p_sleep_request_n_tied;
    @(posedge clk_in) disable iff (!rst_n)
    !SLEEP_REQUEST_N_USED |-> sleep_request_n_out;
  endproperty
  a_sleep_request_n_tied: assert property (p_sleep_request_n_tied)
    else $error("shutdown pin not held high");

  property p_sleep_request_n_tracks;
    @(posedge clk_in) disable iff (!rst_n)
    SLEEP_REQUEST_N_USED |-> (sleep_request_n_out == manual_sleep_force_n_out);
  endproperty
  a_sleep_request_n_tracks: assert property (p_sleep_request_n_tracks)
    else $error("shutdown pin disagrees with force-off");

  property p_only_force_off;
    @(posedge clk_in) disable iff (!rst_n)
    $changed(manual_sleep_force_n_out) |-> $stable(keep_awake_force_out);
  endproperty
  a_only_force_off: assert property (p_only_force_off)
    else $error("force-on moved with force-off");

  property p_manual_hold;
    @(posedge clk_in) disable iff (!rst_n)
    (!auto_mode_in && $stable(manual_sleep_force_n_out))
      |=> keep_awake_force_out;
  endproperty
  a_manual_hold: assert property (p_manual_hold)
    else $error("force-on low under manual control");

  property p_wake_delay;
    @(posedge clk_in) disable iff (!rst_n)
    s_power_up |-> s_wake_quiet;
  endproperty
  a_wake_delay: assert property (p_wake_delay)
    else $error("ready before wake time");

  property p_sleep_drops;
    @(posedge clk_in) disable iff (!rst_n)
    sleep_req_in |=> !manual_sleep_force_n_out && !ready_out;
  endproperty
  a_sleep_drops: assert property (p_sleep_drops)
    else $error("sleep request not obeyed");

  property p_auto_sleep_ready;
    @(posedge clk_in) disable iff (!rst_n)
    (!keep_awake_force_out && !line_active_in) |-> !ready_out;
  endproperty
  a_auto_sleep_ready: assert property (p_auto_sleep_ready)
    else $error("ready during automatic power-down");

endmodule : rpc_power_ctrl

`default_nettype wire
